// File: logic/slfl_engine.sv
/*
 Frame loop engine: APB registers, transmit framer, receive deframer, loop retransmit and 8B/10B coding.
 Assumes one clock pclk, link symbols synchronous to it, and a peer node speaking the same framing.
*/
// Implementation choices: the APB register port and the register offsets.
`timescale 1ns/10ps
`include "slfl_defs.svh"

module slfl_engine #(
	parameter int TX_AW      = 10,
	parameter int RX_AW      = 12,
	parameter int RT_AW      = 10,
	parameter int SUSP_LEVEL = 3072
) (
	input  wire logic                     pclk,
	input  wire logic                     presetn,
	input  wire slfl_pkg::slfl_apb_req_type   apb_req,
	output slfl_pkg::slfl_apb_rsp_type        apb_rsp,
	input  wire logic [39:0]              link_rx_sym,
	input  wire logic                     link_rx_present,
	output logic      [39:0]              link_tx_sym,
	input  wire slfl_pkg::slfl_par_in_type    par_in,
	output slfl_pkg::slfl_par_out_type        par_out,
	output slfl_pkg::slfl_rxdma_type          rxdma,
	input  wire logic                     rxdma_ready,
	output slfl_pkg::slfl_txdma_req_type      txdma_req,
	input  wire slfl_pkg::slfl_txdma_rsp_type txdma_rsp
);
	import slfl_pkg::*;

	localparam int FRAME_WORDS = `SLFL_FRAME_WORDS;
	localparam logic [5:0] T6 [32] = '{
		6'h27, 6'h1D, 6'h2D, 6'h31, 6'h35, 6'h29, 6'h19, 6'h38,
		6'h39, 6'h25, 6'h15, 6'h34, 6'h0D, 6'h2C, 6'h1C, 6'h17,
		6'h1B, 6'h23, 6'h13, 6'h32, 6'h0B, 6'h2A, 6'h1A, 6'h3A,
		6'h33, 6'h26, 6'h16, 6'h36, 6'h0E, 6'h2E, 6'h1E, 6'h2B};
	localparam logic [3:0] T4 [8] = '{4'hB, 4'h9, 4'h5, 4'hC, 4'hD, 4'hA, 4'h6, 4'hE};

	typedef struct packed {
		slfl_txst_type  txst;
		logic [9:0]     wcnt;
		logic           rd;
		logic [39:0]    tx_sym;
		slfl_lword_type rx_w;
		logic           rx_wv;
		logic           in_frame;
		slfl_flags_type rx_flags;
		logic [4:0]     ctrl;
		slfl_flags_type txflags;
		logic [31:0]    prdata;
		logic [31:0]    rxdma_adr;
		logic [31:0]    rxdma_cnt;
		logic [31:0]    txdma_adr;
		logic [31:0]    txdma_cnt;
		logic [31:0]    par_data;
		logic           par_valid;
		logic           par_sync;
		logic           rd_pop;
	} slfl_eng_state_type;

	slfl_eng_state_type s_r;
	slfl_eng_state_type s_nxt;
	logic               tx_push;
	logic [32:0]        tx_wdata;
	logic               tx_pop;
	logic [32:0]        tx_rdata;
	logic               tx_empty;
	logic               tx_full;
	logic               rx_push;
	logic [32:0]        rx_wdata;
	logic               rx_pop;
	logic [32:0]        rx_rdata;
	logic               rx_empty;
	logic [RX_AW:0]     rx_count;
	logic               rt_push;
	logic               rt_pop;
	slfl_lword_type     rt_rdata;
	logic               rt_empty;
	slfl_lword_type     out_w;
	slfl_flags_type     loc_fl;
	logic [8:0]         dv;
	logic [10:0]        ev;
	logic               rd_c;
	logic               rx_ctl;
	logic [7:0]         rx_typ;
	logic               rx_dat;
	logic               my_susp;
	logic               my_nr;
	logic               stall;
	logic               apb_wr;
	logic               apb_rd;
	logic               mapped;
	logic               par_mode;
	logic               rxdma_go;

	// ============================================================
	// 8B/10B coding
	function automatic logic [10:0] slfl_enc(input logic [7:0] b, input logic k, input logic rd);
		logic [5:0] s6;
		logic [3:0] s4;
		logic       u6;
		logic       u4;
		logic       r1;
		s6 = k ? `SLFL_K6_RDN : T6[b[4:0]];
		u6 = ($countones(s6) != 3);
		if (rd && (u6 || (!k && (b[4:0] == 5'h07))))
			s6 = ~s6;
		r1 = rd ^ u6;
		s4 = T4[b[7:5]];
		u4 = ($countones(s4) != 2);
		if (r1 && (u4 || (b[7:5] == 3'h3)))
			s4 = ~s4;
		return {r1 ^ u4, s6, s4};
	endfunction : slfl_enc

	function automatic logic [8:0] slfl_dec(input logic [9:0] c);
		logic [4:0] lo;
		logic [2:0] hi;
		lo = 5'h00;
		hi = 3'h0;
		if ((c[9:4] == `SLFL_K6_RDN) || (c[9:4] == ~`SLFL_K6_RDN))
			return {1'b1, `SLFL_K28_5};
		for (int i = 0; i < 32; i++)
			if ((c[9:4] == T6[i]) || ((c[9:4] == ~T6[i]) && (($countones(T6[i]) != 3) || (i == 7))))
				lo = 5'(i);
		for (int j = 0; j < 8; j++)
			if ((c[3:0] == T4[j]) || ((c[3:0] == ~T4[j]) && (($countones(T4[j]) != 2) || (j == 3))))
				hi = 3'(j);
		return {1'b0, hi, lo};
	endfunction : slfl_dec

	// ============================================================
	// Control words and flag merge
	function automatic slfl_lword_type ctl_word(input logic [7:0] typ, input slfl_flags_type f);
		ctl_word.k = 4'h8;
		ctl_word.d = {`SLFL_K28_5, typ, 2'h0, f, 8'h00};
	endfunction : ctl_word

	function automatic slfl_flags_type merge(input slfl_flags_type f, input logic su, input logic nr);
		merge                 = f;
		merge.suspend_backoff = f.suspend_backoff | su;
		merge.not_ready_flag  = f.not_ready_flag | nr;
	endfunction : merge

	function automatic slfl_lword_type fwd(input slfl_lword_type w, input logic su, input logic nr);
		fwd = w;
		if (w.k[3] && (w.d[31:24] == `SLFL_K28_5))
			fwd.d[13:8] = merge(slfl_flags_type'(w.d[13:8]), su, nr);
	endfunction : fwd

	// ============================================================
	// Memories
	slfl_fifo #(.WIDTH(33), .AW(TX_AW)) u_tx_fifo (
		.clk   (pclk),
		.rst_n (presetn),
		.push  (tx_push),
		.wdata (tx_wdata),
		.pop   (tx_pop),
		.rdata (tx_rdata),
		.empty (tx_empty),
		.full  (tx_full),
		.count ()
	);

	slfl_fifo #(.WIDTH(33), .AW(RX_AW)) u_rx_fifo (
		.clk   (pclk),
		.rst_n (presetn),
		.push  (rx_push),
		.wdata (rx_wdata),
		.pop   (rx_pop),
		.rdata (rx_rdata),
		.empty (rx_empty),
		.full  (),
		.count (rx_count)
	);

	slfl_fifo #(.WIDTH(36), .AW(RT_AW)) u_rt_fifo (
		.clk   (pclk),
		.rst_n (presetn),
		.push  (rt_push),
		.wdata (s_r.rx_w),
		.pop   (rt_pop),
		.rdata (rt_rdata),
		.empty (rt_empty),
		.full  (),
		.count ()
	);

	// ============================================================
	// Decoded word classification, flow control, APB and DMA conditions
	assign par_mode = s_r.ctrl[`SLFL_CTRL_PAR_MODE];
	assign rx_ctl   = s_r.rx_wv && s_r.rx_w.k[3] && (s_r.rx_w.d[31:24] == `SLFL_K28_5);
	assign rx_typ   = s_r.rx_w.d[23:16];
	assign rx_dat   = s_r.rx_wv && !rx_ctl && s_r.in_frame;
	assign my_susp  = s_r.ctrl[`SLFL_CTRL_RX_EN] && (rx_count >= (RX_AW+1)'(SUSP_LEVEL));
	assign my_nr    = s_r.ctrl[`SLFL_CTRL_RX_EN] &&
	                  (par_mode ? par_in.not_ready_flag : s_r.txflags.not_ready_flag);
	assign stall    = s_r.ctrl[`SLFL_CTRL_FLOW_EN] && (s_r.rx_flags.suspend_backoff || !link_rx_present);
	assign apb_wr   = apb_req.psel && apb_req.penable && apb_req.pwrite;
	assign apb_rd   = apb_req.psel && apb_req.penable && !apb_req.pwrite;
	assign mapped   = (apb_req.paddr[1:0] == 2'h0) && (apb_req.paddr <= `SLFL_OFF_TXDMA_CNT);
	assign rxdma_go = !par_mode && (s_r.rxdma_cnt != 32'h0) && !rx_empty && !rx_rdata[32];

	// ============================================================
	// Next state
	always_comb
	begin
		s_nxt    = s_r;
		tx_push  = 1'b0;
		tx_wdata = 33'h0;
		tx_pop   = 1'b0;
		rx_push  = 1'b0;
		rx_wdata = 33'h0;
		rx_pop   = 1'b0;
		rt_push  = 1'b0;
		rt_pop   = 1'b0;
		dv       = 9'h0;
		ev       = 11'h0;
		rd_c     = s_r.rd;
		// Receive decode stage
		s_nxt.rx_wv = link_rx_present;
		for (int l = 0; l < 4; l++)
		begin
			dv                      = slfl_dec(link_rx_sym[l*10 +: 10]);
			s_nxt.rx_w.k[l]         = dv[8];
			s_nxt.rx_w.d[l*8 +: 8]  = dv[7:0];
		end
		// Register reads and writes
		if (apb_req.psel && !apb_req.penable)
		begin
			case (apb_req.paddr)
				`SLFL_OFF_CTRL:      s_nxt.prdata = {27'h0, s_r.ctrl};
				`SLFL_OFF_TXFLAGS:   s_nxt.prdata = {26'h0, s_r.txflags};
				`SLFL_OFF_RXFLAGS:   s_nxt.prdata = {26'h0, s_r.rx_flags};
				`SLFL_OFF_STATUS:    s_nxt.prdata = {16'(rx_count), 11'h0, (s_r.txst == SLFL_ST_DATA),
				                                     rx_empty, tx_full, stall, link_rx_present};
				`SLFL_OFF_RXDATA:    s_nxt.prdata = rx_empty ? 32'h0 : rx_rdata[31:0];
				`SLFL_OFF_RXDMA_ADR: s_nxt.prdata = s_r.rxdma_adr;
				`SLFL_OFF_RXDMA_CNT: s_nxt.prdata = s_r.rxdma_cnt;
				`SLFL_OFF_TXDMA_ADR: s_nxt.prdata = s_r.txdma_adr;
				`SLFL_OFF_TXDMA_CNT: s_nxt.prdata = s_r.txdma_cnt;
				default:             s_nxt.prdata = 32'h0;
			endcase
			// Pop only the word latched here
			s_nxt.rd_pop = (apb_req.paddr == `SLFL_OFF_RXDATA) && !rx_empty && !rx_rdata[32] &&
			               (s_r.rxdma_cnt == 32'h0);
		end
		if (apb_rd && (apb_req.paddr == `SLFL_OFF_RXFLAGS) && s_r.prdata[5])
			s_nxt.rx_flags.sync_marker = 1'b0;
		if (apb_wr)
		begin
			case (apb_req.paddr)
				`SLFL_OFF_CTRL:      s_nxt.ctrl = apb_req.pwdata[4:0];
				`SLFL_OFF_TXFLAGS:   s_nxt.txflags = slfl_flags_type'({1'b0, apb_req.pwdata[4:0]});
				`SLFL_OFF_RXDMA_ADR: s_nxt.rxdma_adr = apb_req.pwdata;
				`SLFL_OFF_RXDMA_CNT: s_nxt.rxdma_cnt = apb_req.pwdata;
				`SLFL_OFF_TXDMA_ADR: s_nxt.txdma_adr = apb_req.pwdata;
				`SLFL_OFF_TXDMA_CNT: s_nxt.txdma_cnt = apb_req.pwdata;
				default:             s_nxt.ctrl = s_r.ctrl;
			endcase
		end
		// Receive deframing
		if (rx_ctl)
		begin
			if (rx_typ == `SLFL_CW_SOF)
				s_nxt.in_frame = 1'b1;
			else if (rx_typ == `SLFL_CW_EOF)
				s_nxt.in_frame = 1'b0;
			if (rx_typ != `SLFL_CW_SYNC)
				s_nxt.rx_flags = slfl_flags_type'({s_nxt.rx_flags.sync_marker, s_r.rx_w.d[12:8]});
		end
		if (s_r.ctrl[`SLFL_CTRL_RX_EN] && (rx_dat || (rx_ctl && (rx_typ == `SLFL_CW_SYNC))))
		begin
			rx_push  = 1'b1;
			rx_wdata = {rx_ctl, rx_ctl ? 32'h0 : s_r.rx_w.d};
		end
		if (s_r.ctrl[`SLFL_CTRL_LOOP_EN] && (rx_dat || (rx_ctl && (rx_typ != `SLFL_CW_IDLE))))
			rt_push = 1'b1;
		// Flags placed in local control words
		if (s_r.ctrl[`SLFL_CTRL_LOOP_EN])
			loc_fl = merge(s_r.rx_flags, my_susp, my_nr);
		else
		begin
			loc_fl                 = par_mode ? par_in.tx_flags : s_r.txflags;
			loc_fl.not_ready_flag  = loc_fl.not_ready_flag | my_nr;
			loc_fl.suspend_backoff = my_susp;
		end
		loc_fl.sync_marker = 1'b0;
		out_w = ctl_word(`SLFL_CW_IDLE, loc_fl);
		// Transmit framing
		case (s_r.txst)
			SLFL_ST_IDLE:
			begin
				if (!rt_empty)
				begin
					out_w  = fwd(rt_rdata, my_susp, my_nr);
					rt_pop = 1'b1;
					if (rt_rdata.k[3] && (rt_rdata.d[23:16] == `SLFL_CW_SOF))
						s_nxt.txst = SLFL_ST_FWD;
				end
				else if (s_r.ctrl[`SLFL_CTRL_TX_EN] && !tx_empty && !stall)
				begin
					out_w      = ctl_word(`SLFL_CW_SOF, loc_fl);
					s_nxt.txst = SLFL_ST_DATA;
					s_nxt.wcnt = 10'h0;
				end
			end
			SLFL_ST_FWD:
			begin
				if (!rt_empty)
				begin
					out_w  = fwd(rt_rdata, my_susp, my_nr);
					rt_pop = 1'b1;
					if (rt_rdata.k[3] && (rt_rdata.d[23:16] == `SLFL_CW_EOF))
						s_nxt.txst = SLFL_ST_IDLE;
				end
			end
			SLFL_ST_DATA:
			begin
				if (s_r.ctrl[`SLFL_CTRL_TX_EN] && !tx_empty && (s_r.wcnt < 10'(FRAME_WORDS)))
				begin
					tx_pop = 1'b1;
					if (tx_rdata[32])
						out_w = ctl_word(`SLFL_CW_SYNC, {1'b1, loc_fl[4:0]});
					else
					begin
						out_w      = '{k: 4'h0, d: tx_rdata[31:0]};
						s_nxt.wcnt = s_r.wcnt + 10'h1;
					end
				end
				else
				begin
					out_w      = ctl_word(`SLFL_CW_EOF, loc_fl);
					s_nxt.txst = SLFL_ST_IDLE;
				end
			end
			default: s_nxt.txst = SLFL_ST_IDLE;
		endcase
		for (int l = 3; l >= 0; l--)
		begin
			ev                        = slfl_enc(out_w.d[l*8 +: 8], out_w.k[l], rd_c);
			s_nxt.tx_sym[l*10 +: 10]  = ev[9:0];
			rd_c                      = ev[10];
		end
		s_nxt.rd = rd_c;
		// Transmit FIFO fill
		if (par_mode)
		begin
			if (par_in.word_valid_strobe)
			begin
				tx_push  = 1'b1;
				tx_wdata = {1'b0, par_in.tx_data};
			end
			else if (par_in.sync_marker)
			begin
				tx_push  = 1'b1;
				tx_wdata = {1'b1, 32'h0};
			end
		end
		else if (txdma_req.req && txdma_rsp.valid)
		begin
			tx_push         = 1'b1;
			tx_wdata        = {1'b0, txdma_rsp.data};
			s_nxt.txdma_adr = s_r.txdma_adr + 32'h4;
			s_nxt.txdma_cnt = s_r.txdma_cnt - 32'h1;
		end
		else if (apb_wr && ((apb_req.paddr == `SLFL_OFF_TXDATA) || (apb_req.paddr == `SLFL_OFF_TXSYNC)))
		begin
			tx_push  = 1'b1;
			tx_wdata = (apb_req.paddr == `SLFL_OFF_TXSYNC) ? {1'b1, 32'h0} : {1'b0, apb_req.pwdata};
		end
		// Receive FIFO drain
		s_nxt.par_valid = 1'b0;
		s_nxt.par_sync  = 1'b0;
		if (par_mode)
		begin
			if (!par_in.suspend_backoff && !par_in.not_ready_flag && !rx_empty)
			begin
				rx_pop          = 1'b1;
				s_nxt.par_valid = !rx_rdata[32];
				s_nxt.par_sync  = rx_rdata[32];
				s_nxt.par_data  = rx_rdata[31:0];
			end
		end
		else if (!rx_empty && rx_rdata[32])
		begin
			rx_pop                     = 1'b1;
			s_nxt.rx_flags.sync_marker = 1'b1;
		end
		else if (rxdma_go && rxdma_ready)
		begin
			rx_pop          = 1'b1;
			s_nxt.rxdma_adr = s_r.rxdma_adr + 32'h4;
			s_nxt.rxdma_cnt = s_r.rxdma_cnt - 32'h1;
		end
		else if (apb_rd && (apb_req.paddr == `SLFL_OFF_RXDATA) && s_r.rd_pop)
			rx_pop = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			s_r         <= '0;
			s_r.ctrl    <= `SLFL_CTRL_RST;
			s_r.txflags <= `SLFL_FLAGS_RST;
		end
		else
			s_r <= s_nxt;
	end

	// ============================================================
	// Outputs
	assign apb_rsp.pready   = 1'b1;
	assign apb_rsp.pslverr  = apb_req.psel && apb_req.penable && !mapped;
	assign apb_rsp.prdata   = s_r.prdata;
	assign link_tx_sym      = s_r.tx_sym;
	assign par_out.rx_data  = s_r.par_data;
	assign par_out.word_valid_strobe = s_r.par_valid;
	assign par_out.sync_marker = s_r.par_sync;
	assign par_out.rx_flags = s_r.rx_flags;
	assign par_out.tx_hold  = tx_full;
	assign rxdma.valid      = rxdma_go;
	assign rxdma.addr       = s_r.rxdma_adr;
	assign rxdma.data       = rx_rdata[31:0];
	assign txdma_req.req    = !par_mode && (s_r.txdma_cnt != 32'h0) && !tx_full;
	assign txdma_req.addr   = s_r.txdma_adr;

endmodule : slfl_engine

// File: shared/slfl_defs.svh
/*
 Register offsets, field positions, link codes and timing counts of the frame loop engine.
 Assumes an including file that is compiled with the frame loop package.
*/
`ifndef SLFL_DEFS_SVH
`define SLFL_DEFS_SVH

// ============================================================
// Register offsets
`define SLFL_OFF_CTRL      12'h000
`define SLFL_OFF_TXFLAGS   12'h004
`define SLFL_OFF_RXFLAGS   12'h008
`define SLFL_OFF_STATUS    12'h00C
`define SLFL_OFF_TXDATA    12'h010
`define SLFL_OFF_TXSYNC    12'h014
`define SLFL_OFF_RXDATA    12'h018
`define SLFL_OFF_RXDMA_ADR 12'h01C
`define SLFL_OFF_RXDMA_CNT 12'h020
`define SLFL_OFF_TXDMA_ADR 12'h024
`define SLFL_OFF_TXDMA_CNT 12'h028

// ============================================================
// Control fields and reset values
`define SLFL_CTRL_TX_EN    0
`define SLFL_CTRL_RX_EN    1
`define SLFL_CTRL_LOOP_EN  2
`define SLFL_CTRL_FLOW_EN  3
`define SLFL_CTRL_PAR_MODE 4
`define SLFL_CTRL_RST      5'h0B
`define SLFL_FLAGS_RST     6'h00

// ============================================================
// Link control words
`define SLFL_K28_5         8'hBC
`define SLFL_K6_RDN        6'h0F
`define SLFL_CW_IDLE       8'h01
`define SLFL_CW_SOF        8'h02
`define SLFL_CW_EOF        8'h03
`define SLFL_CW_SYNC       8'h04

// ============================================================
// Frame size and timing
`define SLFL_FRAME_BYTES   2048
`define SLFL_FRAME_WORDS   (`SLFL_FRAME_BYTES / 4)
`define SLFL_CLK_MHZ       40
`define SLFL_LAT_NS        500
`define SLFL_LAT_CYC       ((`SLFL_LAT_NS * `SLFL_CLK_MHZ) / 1000)

`endif

// File: shared/slfl_pkg.sv
/*
 Types shared by the frame loop engine, its checker and its bench.
 Assumes the constants header is on the include path.
*/
package slfl_pkg;

	// ============================================================
	// Side-band flags, field order gives not_ready as bit 0
	typedef struct packed {
		logic sync_marker;
		logic user_flag_two;
		logic user_flag_one;
		logic suspend_backoff;
		logic direction_flag;
		logic not_ready_flag;
	} slfl_flags_type;

	// ============================================================
	// Link word before encoding, k bit 3 belongs to byte 31:24
	typedef struct packed {
		logic [3:0]  k;
		logic [31:0] d;
	} slfl_lword_type;

	typedef enum logic [1:0] {SLFL_ST_IDLE, SLFL_ST_FWD, SLFL_ST_DATA} slfl_txst_type;

	// ============================================================
	// APB
	typedef struct packed {
		logic        psel;
		logic        penable;
		logic        pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
	} slfl_apb_req_type;

	typedef struct packed {
		logic        pready;
		logic        pslverr;
		logic [31:0] prdata;
	} slfl_apb_rsp_type;

	// ============================================================
	// Parallel port
	typedef struct packed {
		logic [31:0]    tx_data;
		logic           word_valid_strobe;
		logic           sync_marker;
		slfl_flags_type tx_flags;
		logic           suspend_backoff;
		logic           not_ready_flag;
	} slfl_par_in_type;

	typedef struct packed {
		logic [31:0]    rx_data;
		logic           word_valid_strobe;
		logic           sync_marker;
		slfl_flags_type rx_flags;
		logic           tx_hold;
	} slfl_par_out_type;

	// ============================================================
	// DMA channels
	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] data;
	} slfl_rxdma_type;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} slfl_txdma_req_type;

	typedef struct packed {
		logic        valid;
		logic [31:0] data;
	} slfl_txdma_rsp_type;

endpackage : slfl_pkg

// File: logic/slfl_fifo.sv
/*
 Synchronous FIFO with a registered head word.
 Assumes push is ignored when full and pop when empty.
*/
`timescale 1ns/10ps

module slfl_fifo #(
	parameter int WIDTH = 33,
	parameter int AW    = 4
) (
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             push,
	input  wire logic [WIDTH-1:0] wdata,
	input  wire logic             pop,
	output logic      [WIDTH-1:0] rdata,
	output logic                  empty,
	output logic                  full,
	output logic      [AW:0]      count
);

	typedef struct packed {
		logic [AW-1:0]    wp;
		logic [AW-1:0]    rp;
		logic [AW:0]      cnt;
		logic [WIDTH-1:0] head;
	} slfl_fifo_state_type;

	slfl_fifo_state_type s_r;
	slfl_fifo_state_type s_nxt;
	logic [WIDTH-1:0]    mem [2**AW];
	logic                do_push;
	logic                do_pop;

	// ============================================================
	// Pointers and head word
	always_comb
	begin
		s_nxt   = s_r;
		do_push = push && (s_r.cnt != (AW+1)'(2**AW));
		do_pop  = pop && (s_r.cnt != '0);
		s_nxt.wp  = s_r.wp + AW'(do_push);
		s_nxt.rp  = s_r.rp + AW'(do_pop);
		s_nxt.cnt = s_r.cnt + (AW+1)'(do_push) - (AW+1)'(do_pop);
		if (do_push && ((s_r.cnt == '0) || ((s_r.cnt == (AW+1)'(1)) && do_pop)))
			s_nxt.head = wdata;
		else
			s_nxt.head = mem[s_nxt.rp];
	end

	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	always_ff @(posedge clk)
	begin
		if (do_push)
			mem[s_r.wp] <= wdata;
	end

	assign rdata = s_r.head;
	assign empty = (s_r.cnt == '0);
	assign full  = (s_r.cnt == (AW+1)'(2**AW));
	assign count = s_r.cnt;

endmodule : slfl_fifo

// File: dv/slfl_engine_checker.sv
/*
 Port assertions for the frame loop engine.
 Assumes the engine top and its package.
*/
`timescale 1ns/10ps
module slfl_engine_checker (
	input wire logic                         pclk,
	input wire logic                         presetn,
	input wire slfl_pkg::slfl_apb_req_type   apb_req,
	input wire slfl_pkg::slfl_apb_rsp_type   apb_rsp,
	input wire logic [39:0]                  link_tx_sym,
	input wire slfl_pkg::slfl_par_in_type    par_in,
	input wire slfl_pkg::slfl_par_out_type   par_out,
	input wire slfl_pkg::slfl_rxdma_type     rxdma,
	input wire logic                         rxdma_ready
);
	import slfl_pkg::*;
	// ============================================================
	// Assertions
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	wire acc = apb_req.psel && apb_req.penable;
	wire dma = rxdma.valid && rxdma_ready;
	AST_PREADY_HIGH: assert property (apb_rsp.pready) else $error("pready low");
	AST_SLVERR_HIGH: assert property (
		acc && apb_req.paddr > 12'h028 |-> apb_rsp.pslverr) else $error("no slverr");
	AST_SLVERR_LOW: assert property (
		acc && apb_req.paddr <= 12'h028 && apb_req.paddr[1:0] == 2'h0 |-> !apb_rsp.pslverr) else $error("slverr");
	AST_PRDATA_HOLD: assert property (
		acc && !apb_req.pwrite ##1 !apb_req.psel |-> $stable(apb_rsp.prdata)) else $error("prdata moved");
	AST_STROBE_GATED: assert property (
		par_out.word_valid_strobe |-> $past(!par_in.suspend_backoff && !par_in.not_ready_flag)) else $error("strobe");
	AST_DMA_STEP: assert property (dma |=> rxdma.addr == $past(rxdma.addr) + 32'h4) else $error("dma step");
	AST_DMA_HOLD: assert property (
		!dma && !(acc && apb_req.pwrite) |=> $stable(rxdma.addr)) else $error("dma addr moved");
	AST_LINK_CODED: assert property ($past(presetn) |-> link_tx_sym != 40'h0) else $error("link zero");
	COV_DMA: cover property (dma);
	COV_STROBE: cover property (par_out.word_valid_strobe);
	COV_SLVERR: cover property (acc && apb_rsp.pslverr);
endmodule : slfl_engine_checker

bind slfl_engine slfl_engine_checker CHK (.pclk(pclk), .presetn(presetn), .apb_req(apb_req), .apb_rsp(apb_rsp),
	.link_tx_sym(link_tx_sym), .par_in(par_in), .par_out(par_out), .rxdma(rxdma), .rxdma_ready(rxdma_ready));

// File: dv/slfl_peer_loop.sv
/*
 Far side: a ring closed straight back to the node.
 Assumes the node is the only non-loop node.
*/
`timescale 1ns/10ps
module slfl_peer_loop (
	input wire logic  pclk,
	input wire logic  [39:0] tx_sym,
	output logic      [39:0] rx_sym,
	output logic      present
);
	logic [39:0] dly_r;
	assign present = 1'b1;
	always @(posedge pclk)
		dly_r <= tx_sym;
	assign rx_sym = dly_r;
endmodule : slfl_peer_loop

// File: dv/test_slfl_engine.sv
/*
 Self-checking bench for the frame loop engine.
 Assumes the loop peer model and checker alongside.
*/
`timescale 1ns/10ps
module test_slfl_engine;
	import slfl_pkg::*;
	logic               pclk = 0;
	logic               presetn = 0;
	logic               rxdma_ready = 0;
	logic               rx_present;
	logic [39:0]        rx_sym;
	logic [39:0]        tx_sym;
	slfl_apb_req_type   apb_req = '0;
	slfl_apb_rsp_type   apb_rsp;
	slfl_par_in_type    par_in = '0;
	slfl_par_out_type   par_out;
	slfl_rxdma_type     rxdma;
	slfl_txdma_req_type txdma_req;
	slfl_txdma_rsp_type txdma_rsp = '0;
	int                 err_total = 0;
	int                 samples_checked = 0;
	int                 seed = 65810;
	logic [32:0]        exp_q[$];
	logic [32:0]        rd_q[$];
	logic [31:0]        w;
	logic [31:0]        dma_adr = 32'h200;

	always #12.5 pclk = ~pclk;
	always @(posedge pclk)
		rxdma_ready <= 1'($random(seed));

	// Transmit DMA responder, one word per req and valid edge
	always @(posedge pclk)
	begin
		if (txdma_req.req && txdma_rsp.valid)
		begin
			exp_q.push_back({1'b0, txdma_rsp.data});
			check({1'b0, txdma_req.addr}, {1'b0, dma_adr});
			dma_adr <= dma_adr + 32'h4;
		end
		if (!txdma_rsp.valid || txdma_req.req)
			txdma_rsp <= '{1'b1, 32'($random(seed))};
	end

	slfl_engine #(.TX_AW(4), .RX_AW(4), .RT_AW(4), .SUSP_LEVEL(12)) DUT (.pclk(pclk), .presetn(presetn),
		.apb_req(apb_req), .apb_rsp(apb_rsp), .link_rx_sym(rx_sym), .link_rx_present(rx_present),
		.link_tx_sym(tx_sym), .par_in(par_in), .par_out(par_out), .rxdma(rxdma), .rxdma_ready(rxdma_ready),
		.txdma_req(txdma_req), .txdma_rsp(txdma_rsp));
	slfl_peer_loop PEER (.pclk(pclk), .tx_sym(tx_sym), .rx_sym(rx_sym), .present(rx_present));

	// ============================================================
	// Tasks
	task automatic check(input logic [32:0] seen, input logic [32:0] want);
		samples_checked++;
		if (seen !== want)
		begin
			err_total++;
			$display("mismatch at %0t: saw %h, expected %h", $time, seen, want);
		end
	endtask : check

	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, input logic [32:0] want);
		int n;
		n = 0;
		@(posedge pclk);
		if (!wr)
			rd_q.push_back(want);
		apb_req <= '{1'b1, 1'b0, wr, a, d};
		@(posedge pclk);
		apb_req.penable <= 1'b1;
		do
			@(posedge pclk);
		while (apb_rsp.pready !== 1'b1 && ++n < 50);
		apb_req <= '0;
	endtask : apb

	task automatic drain();
		for (int i = 0; i < 200 && exp_q.size() > 0; i++)
			@(posedge pclk);
		check(33'(exp_q.size()), 33'h0);
	endtask : drain

	task automatic close_out();
		$display("checks %0d, mismatches %0d", samples_checked, err_total);
		if (err_total == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : close_out

	// ============================================================
	// Monitor
	always @(posedge pclk)
	begin
		if (apb_req.psel && apb_req.penable && !apb_req.pwrite && apb_rsp.pready)
			check(apb_rsp.pslverr ? 33'h100000000 : {1'b0, apb_rsp.prdata}, rd_q.pop_front());
		if (rxdma.valid && rxdma_ready)
			check({1'b0, rxdma.data}, exp_q.size() ? exp_q.pop_front() : 33'h1FFFFFFFF);
		if (par_out.word_valid_strobe)
			check({1'b0, par_out.rx_data}, exp_q.size() ? exp_q.pop_front() : 33'h1FFFFFFFF);
	end

	// ============================================================
	// Tests
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1'b1;
		apb(0, 12'h000, 0, 33'h00000000B);
		apb(0, 12'h004, 0, 33'h0);
		apb(0, 12'h02C, 0, 33'h100000000);
		apb(1, 12'h004, 32'h1B, 0);
		repeat (20) @(posedge pclk);
		apb(0, 12'h008, 0, 33'h01B);
		apb(1, 12'h014, 0, 0);
		repeat (20) @(posedge pclk);
		apb(0, 12'h008, 0, 33'h03B);
		apb(0, 12'h008, 0, 33'h01B);
		$display("test 1 done");
		apb(1, 12'h01C, 32'h100, 0);
		apb(1, 12'h020, 32'h4, 0);
		repeat (4)
		begin
			w = $random(seed);
			exp_q.push_back({1'b0, w});
			apb(1, 12'h010, w, 0);
		end
		drain();
		apb(1, 12'h020, 32'h3, 0);
		apb(1, 12'h024, 32'h200, 0);
		apb(1, 12'h028, 32'h3, 0);
		repeat (6) @(posedge pclk);
		drain();
		apb(0, 12'h01C, 0, 33'h11C);
		apb(0, 12'h020, 0, 33'h0);
		apb(0, 12'h028, 0, 33'h0);
		w = $random(seed);
		apb(1, 12'h010, w, 0);
		repeat (40) @(posedge pclk);
		apb(0, 12'h018, 0, {1'b0, w});
		$display("test 2 done");
		apb(1, 12'h000, 32'h1B, 0);
		par_in.tx_flags <= 6'h3F;
		for (int k = 0; k < 2; k++)
		begin
			par_in.suspend_backoff <= (k == 0);
			par_in.not_ready_flag <= (k == 1);
			repeat (3)
			begin
				@(posedge pclk);
				w = $random(seed);
				par_in.tx_data <= w;
				par_in.word_valid_strobe <= 1'b1;
				exp_q.push_back({1'b0, w});
			end
			@(posedge pclk);
			par_in.word_valid_strobe <= 1'b0;
			repeat (40) @(posedge pclk);
			check(33'(exp_q.size()), 33'h3);
			check({32'h0, par_out.rx_flags.suspend_backoff}, 33'h0);
			par_in.suspend_backoff <= 1'b0;
			par_in.not_ready_flag <= 1'b0;
			drain();
		end
		$display("test 3 done");
		close_out();
	end

	initial
	begin
		#(100us);
		err_total++;
		close_out();
	end
endmodule : test_slfl_engine
